/* pci_cfg.svh */
// register offsets, field positions and reset values of the pin change block
`ifndef PCI_CFG_SVH
`define PCI_CFG_SVH
`define PCI_OFS_GROUP_EN 12'h000
`define PCI_OFS_GROUP_FLAGS 12'h004
`define PCI_OFS_MASK_HIGH 12'h008
`define PCI_OFS_MASK_MIDDLE 12'h00c
`define PCI_OFS_MASK_LOW 12'h010
`define PCI_OFS_IRQ_STATUS 12'h014
`define PCI_OFS_IRQ_MASK 12'h018
`define PCI_GRP_LOW 0
`define PCI_GRP_MIDDLE 1
`define PCI_GRP_HIGH 2
`define PCI_RST_BYTE 8'h00
`define PCI_RST_GROUP 3'h0
`define PCI_MIDDLE_MASK_BITS 8'h7f
`endif

/* pci_pkg.sv */
// types shared by the pin change block
package pci_pkg;
	typedef logic [2:0] pci_group_t;
	typedef logic [7:0] pci_byte_t;
	typedef logic [22:0] pci_pins_t;
endpackage

/* pci_ctrl.sv */
// pin change interrupt controller with apb register access
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "pci_cfg.svh"

module pci_ctrl (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire pci_pkg::pci_byte_t high_group_pins,
	input wire logic [6:0] middle_group_pins,
	input wire pci_pkg::pci_byte_t low_group_pins,
	input wire logic global_irq_enable,
	input wire pci_pkg::pci_group_t vector_ack,
	output pci_pkg::pci_group_t group_irq_req,
	output logic high_group_vector,
	output logic middle_group_vector,
	output logic low_group_vector,
	output logic irq
);
	import pci_pkg::*;

	pci_pins_t pin_meta_r;
	pci_pins_t pin_sync_r;
	pci_pins_t pin_prev_r;
	logic [2:0] armed_r;
	pci_pins_t pins_in;
	pci_pins_t change;
	pci_pins_t watched;
	pci_group_t group_hit;
	pci_group_t pin_group_irq_enable_r;
	pci_group_t pin_group_irq_flags_r;
	pci_group_t irq_status_r;
	pci_group_t irq_mask_r;
	pci_group_t flag_clear;
	pci_group_t flags_nxt;
	pci_byte_t pin_mask_high_group_r;
	logic [6:0] pin_mask_middle_group_r;
	pci_byte_t pin_mask_low_group_r;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic [31:0] rdata_nxt;

	assign pins_in = {high_group_pins, middle_group_pins, low_group_pins};

	// two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta_r <= 23'h000000;
			pin_sync_r <= 23'h000000;
		end else begin
			pin_meta_r <= pins_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// previous sample of each synchronised pin
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_prev_r <= 23'h000000;
		end else begin
			pin_prev_r <= pin_sync_r;
		end
	end

	// the chain and the previous sample start at zero, so a pin held
	// high through reset would look like a change to a mask written
	// right after release; detection waits until all stages are real
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_r <= 3'h0;
		end else begin
			armed_r <= {armed_r[1:0], 1'b1};
		end
	end

	// change detection gated per pin by the mask registers
	assign change = (pin_sync_r ^ pin_prev_r) & {23{armed_r[2]}};
	assign watched = change & {pin_mask_high_group_r,
		pin_mask_middle_group_r, pin_mask_low_group_r};
	assign group_hit[`PCI_GRP_HIGH] = |watched[22:15];
	assign group_hit[`PCI_GRP_MIDDLE] = |watched[14:8];
	assign group_hit[`PCI_GRP_LOW] = |watched[7:0];

	// apb decode: no wait states, unmapped addresses answer with pslverr
	assign wr_en = psel & penable & pwrite;
	assign rd_en = psel & penable & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		addr_ok = 1'b1;
		rdata_nxt = 32'h00000000;
		unique case (paddr)
			`PCI_OFS_GROUP_EN: rdata_nxt[2:0] = pin_group_irq_enable_r;
			`PCI_OFS_GROUP_FLAGS: rdata_nxt[2:0] = pin_group_irq_flags_r;
			`PCI_OFS_MASK_HIGH: rdata_nxt[7:0] = pin_mask_high_group_r;
			`PCI_OFS_MASK_MIDDLE: rdata_nxt[6:0] = pin_mask_middle_group_r;
			`PCI_OFS_MASK_LOW: rdata_nxt[7:0] = pin_mask_low_group_r;
			`PCI_OFS_IRQ_STATUS: rdata_nxt[2:0] = irq_status_r;
			`PCI_OFS_IRQ_MASK: rdata_nxt[2:0] = irq_mask_r;
			default: addr_ok = 1'b0;
		endcase
	end
	assign pslverr = psel & penable & ~addr_ok;

	// read data is registered at the end of the setup cycle, valid in the access cycle
	// the master samples it only after pready; held between reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (psel & ~penable & ~pwrite) begin
			prdata <= rdata_nxt;
		end
	end

	// writable control registers; upper bits are not stored at all
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_group_irq_enable_r <= `PCI_RST_GROUP;
			pin_mask_high_group_r <= `PCI_RST_BYTE;
			pin_mask_middle_group_r <= 7'h00;
			pin_mask_low_group_r <= `PCI_RST_BYTE;
			irq_mask_r <= `PCI_RST_GROUP;
		end else if (wr_en) begin
			unique case (paddr)
				`PCI_OFS_GROUP_EN: pin_group_irq_enable_r <= pwdata[2:0];
				`PCI_OFS_MASK_HIGH: pin_mask_high_group_r <= pwdata[7:0];
				`PCI_OFS_MASK_MIDDLE: pin_mask_middle_group_r <= pwdata[6:0];
				`PCI_OFS_MASK_LOW: pin_mask_low_group_r <= pwdata[7:0];
				`PCI_OFS_IRQ_MASK: irq_mask_r <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// flag clear sources: write-one-to-clear and vector acknowledge
	assign flag_clear = ((wr_en && paddr == `PCI_OFS_GROUP_FLAGS) ?
		pwdata[2:0] : 3'h0) | vector_ack;
	// a change in the same cycle as a clear wins, so no event is lost
	assign flags_nxt = (pin_group_irq_flags_r & ~flag_clear) | group_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_group_irq_flags_r <= `PCI_RST_GROUP;
		end else begin
			pin_group_irq_flags_r <= flags_nxt;
		end
	end

	// sticky status of the same events; a read clears only the bits it
	// returned, so an event landing in the read's setup cycle survives
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_r <= `PCI_RST_GROUP;
		end else if (rd_en && paddr == `PCI_OFS_IRQ_STATUS) begin
			irq_status_r <= (irq_status_r & ~prdata[2:0]) | group_hit;
		end else begin
			irq_status_r <= irq_status_r | group_hit;
		end
	end

	// per-group request; global enable is applied by the core
	assign group_irq_req = pin_group_irq_flags_r & pin_group_irq_enable_r;
	// separate vectors, each needing the global enable too
	assign high_group_vector = group_irq_req[`PCI_GRP_HIGH] &
		global_irq_enable;
	assign middle_group_vector = group_irq_req[`PCI_GRP_MIDDLE] &
		global_irq_enable;
	assign low_group_vector = group_irq_req[`PCI_GRP_LOW] &
		global_irq_enable;
	assign irq = |(irq_status_r & irq_mask_r);
endmodule // pci_ctrl

/* pci_ctrl_props.sv */
// port assertions of the pin change controller
`timescale 1ns/100ps
module pci_ctrl_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic global_irq_enable,
	input wire pci_pkg::pci_group_t group_irq_req,
	input wire logic high_group_vector,
	input wire logic middle_group_vector,
	input wire logic low_group_vector
);
	import pci_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states: a stuck master would hang the core
	AST_READY: assert property (psel && penable |-> pready)
		else $error("access without ready");
	AST_BAD_ADDR: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
		else $error("unmapped access not refused");
	AST_BAD_RD: assert property (psel && penable && !pwrite && paddr > 12'h018
		|-> !prdata) else $error("unmapped read not zero");
	AST_GRP_UPPER: assert property (psel && penable && !pwrite && paddr < 12'h008
		|-> prdata[31:3] == '0) else $error("group bits 7..3 not zero");
	AST_MID_TOP: assert property (psel && penable && !pwrite && paddr == 12'h00c
		|-> prdata[31:7] == '0) else $error("middle mask bit 7 not zero");
	AST_HIGH_VEC: assert property (high_group_vector ==
		(group_irq_req[2] && global_irq_enable)) else $error("high vector");
	AST_MID_VEC: assert property (middle_group_vector ==
		(group_irq_req[1] && global_irq_enable)) else $error("middle vector");
	AST_LOW_VEC: assert property (low_group_vector ==
		(group_irq_req[0] && global_irq_enable)) else $error("low vector");
endmodule // pci_ctrl_props

/* pci_pin_drv.sv */
// external pin levels, toggled where flip is set
`timescale 1ns/100ps
module pci_pin_drv (
	input wire logic pclk,
	input wire logic [22:0] flip,
	output logic [22:0] pins
);
	// pins move just after an edge, like slow external levels
	initial pins = '0;
	always @(posedge pclk) pins <= pins ^ flip;
endmodule // pci_pin_drv

/* pin_change_interrupt_ctrl_tb.sv */
// self-checking bench of the pin change controller
`timescale 1ns/100ps
module pin_change_interrupt_ctrl_tb;
	import pci_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, gie = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, q;
	logic pready, pslverr, irq, err;
	pci_group_t ack = '0, req, vec;
	logic [22:0] flip = '0, pins;
	int miscompares = 0, compares = 0, lfsr = 88162, en, fl, mk, m;
	always #5 pclk = ~pclk;
	pci_pin_drv drv (.pclk(pclk), .flip(flip), .pins(pins));
	pci_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .high_group_pins(pins[22:15]),
		.middle_group_pins(pins[14:8]), .low_group_pins(pins[7:0]),
		.global_irq_enable(gie), .vector_ack(ack), .group_irq_req(req),
		.high_group_vector(vec[2]), .middle_group_vector(vec[1]),
		.low_group_vector(vec[0]), .irq);
	function int rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction
	task chk(input logic [31:0] got, input int exp);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// apb cycle; trailing idle edge keeps strobes from being set twice
	task apb(input logic w, input logic [11:0] a, input int d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task conclude;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge pclk);
		miscompares++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		for (int a = 0; a < 32; a += 4) begin
			apb(0, a[11:0], 0);
			chk(q, 0);
			chk(err, a > 24);
		end
		$display("reset values done");
		apb(1, 12'h018, 7);
		for (int i = 0; i < 6; i++) begin
			en = rnd();
			mk = rnd();
			gie <= mk[31];
			apb(1, 12'h000, en);
			en &= 7;
			apb(1, 12'h008, mk >> 16);
			apb(1, 12'h00c, mk >> 8);
			apb(1, 12'h010, mk);
			apb(0, 12'h00c, 0);
			chk(q, (mk >> 8) & 'h7f);
			apb(0, 12'h000, 0);
			chk(q, en);
			m = rnd();
			flip <= m[22:0];
			@(posedge pclk);
			flip <= '0;
			repeat (5) @(posedge pclk);
			fl = {|(m[22:15] & mk[23:16]), |(m[14:8] & mk[14:8]), |(m & mk & 255)};
			chk(req, fl & en);
			chk(vec, fl & en & {3{gie}});
			chk(irq, fl != 0);
			apb(0, 12'h004, 0);
			chk(q, fl);
			apb(0, 12'h014, 0);
			chk(q, fl);
			chk(irq, 0);
			m = rnd();
			apb(1, 12'h004, m);
			apb(0, 12'h004, 0);
			chk(q, fl & ~m);
			ack <= 3'h7;
			@(posedge pclk);
			ack <= '0;
			apb(0, 12'h004, 0);
			chk(q, 0);
			$display("pin change pass %0d done", i);
		end
		// reset with pins left high, masks opened at once: no false change
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		apb(1, 12'h008, -1);
		apb(1, 12'h00c, -1);
		apb(1, 12'h010, -1);
		repeat (4) @(posedge pclk);
		apb(0, 12'h004, 0);
		chk(q, 0);
		chk(irq, 0);
		$display("reset with pins held done");
		conclude;
	end
endmodule // pin_change_interrupt_ctrl_tb
bind pci_ctrl pci_ctrl_props u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .global_irq_enable,
	.group_irq_req, .high_group_vector, .middle_group_vector, .low_group_vector);
